//--- include/ulsw_pkg.sv
// package for the usb2 port line swap register block
package ulsw_pkg;
  localparam int unsigned ULSW_NUM_PORTS = 5;
  localparam logic [7:0] ULSW_CTRL_OFFSET = 8'h0B;
  localparam logic [7:0] ULSW_CTRL_RESET = 8'h00;
  localparam int unsigned ULSW_UNLOCK_BIT = 7;
  localparam int unsigned ULSW_RSVD_HI = 6;
  localparam int unsigned ULSW_RSVD_LO = 5;
  localparam int unsigned ULSW_SWAP_LSB = 0;

  // one register access, byte wide
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ulsw_req_s;

  // one usb2 line pair, dm then dp
  typedef struct packed {
    logic dm;
    logic dp;
  } ulsw_pair_s;
endpackage : ulsw_pkg

//--- hw/ulsw_pair_mux.sv
// per-port dm/dp exchange between the core side and the pins
module ulsw_pair_mux
  import ulsw_pkg::*;
#(
  parameter int unsigned NUM_PORTS = ULSW_NUM_PORTS
) (
  // control
  input wire logic [NUM_PORTS-1:0] i_swap,
  // core side lines
  input wire ulsw_pkg::ulsw_pair_s [NUM_PORTS-1:0] i_core,
  // pin side lines
  output logic [NUM_PORTS-1:0] o_pin_dm,
  output logic [NUM_PORTS-1:0] o_pin_dp
);
  import ulsw_pkg::*;

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (i_swap[i]) begin
        o_pin_dm[i] = i_core[i].dp;
        o_pin_dp[i] = i_core[i].dm;
      end else begin
        o_pin_dm[i] = i_core[i].dm;
        o_pin_dp[i] = i_core[i].dp;
      end
    end
  end
endmodule : ulsw_pair_mux

//--- hw/ulsw_line_swap_reg.sv
// usb2 line swap control register with otp fallback and pair routing
module ulsw_line_swap_reg
  import ulsw_pkg::*;
#(
  parameter int unsigned NUM_PORTS = ULSW_NUM_PORTS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // register access from smbus or eeprom loader
  input wire ulsw_pkg::ulsw_req_s i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // one-time-programmable swap values
  input wire logic [NUM_PORTS-1:0] i_otp_swap,
  // usb2 lines
  input wire ulsw_pkg::ulsw_pair_s [NUM_PORTS-1:0] i_core,
  output logic [NUM_PORTS-1:0] o_pin_dm,
  output logic [NUM_PORTS-1:0] o_pin_dp
);
  import ulsw_pkg::*;

  logic unlock_r, unlock_nxt;
  logic [NUM_PORTS-1:0] swap_r, swap_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [NUM_PORTS-1:0] eff_swap;
  logic [NUM_PORTS-1:0] pdm_r, pdp_r, pdm_nxt, pdp_nxt, mux_dm, mux_dp;
  logic hit_wr, hit_rd;

  // one decoder for write, read and all checks but a_read_otp_val, so the map cannot drift apart
  function automatic logic is_ctrl(input logic [7:0] a);
    return a == ULSW_CTRL_OFFSET;
  endfunction : is_ctrl

  // locked bits always mirror otp, so otp changes show without a write
  assign eff_swap = unlock_r ? swap_r : i_otp_swap;
  assign hit_wr = i_req.wr && is_ctrl(i_req.addr);
  assign hit_rd = i_req.rd && is_ctrl(i_req.addr);

  function automatic logic [7:0] pack_reg(input logic ul, input logic [NUM_PORTS-1:0] sw);
    logic [7:0] v;
    v = 8'h00;
    v[ULSW_UNLOCK_BIT] = ul;
    v[ULSW_SWAP_LSB +: NUM_PORTS] = sw;
    return v;
  endfunction : pack_reg

  always_comb begin
    unlock_nxt = unlock_r;
    swap_nxt = swap_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (hit_wr) begin
      unlock_nxt = i_req.wdata[ULSW_UNLOCK_BIT];
      if (i_req.wdata[ULSW_UNLOCK_BIT]) begin
        swap_nxt = i_req.wdata[ULSW_SWAP_LSB +: NUM_PORTS];
      end else begin
        swap_nxt = i_otp_swap;
      end
    end
    if (i_req.rd) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = hit_rd ? pack_reg(unlock_r, eff_swap) : 8'h00;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      unlock_r <= ULSW_CTRL_RESET[ULSW_UNLOCK_BIT];
      swap_r <= ULSW_CTRL_RESET[ULSW_SWAP_LSB +: NUM_PORTS];
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      unlock_r <= unlock_nxt;
      swap_r <= swap_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  ulsw_pair_mux #(.NUM_PORTS(NUM_PORTS)) u_mux (
    .i_swap(eff_swap),
    .i_core(i_core),
    .o_pin_dm(mux_dm),
    .o_pin_dp(mux_dp)
  );

  // registered pin drive; one cycle latency traded for clean outputs
  always_comb begin
    pdm_nxt = mux_dm;
    pdp_nxt = mux_dp;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pdm_r <= '0;
      pdp_r <= '0;
    end else begin
      pdm_r <= pdm_nxt;
      pdp_r <= pdp_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_pin_dm = pdm_r;
  assign o_pin_dp = pdp_r;

  // assertions
  a_locked_ignores_wr: assert property (@(posedge i_clk) disable iff (i_reset)
    (hit_wr && !i_req.wdata[ULSW_UNLOCK_BIT]) |=> (!unlock_r && eff_swap == i_otp_swap))
    else $error("locked write changed swap bits");
  a_unlock_same_wr: assert property (@(posedge i_clk) disable iff (i_reset)
    (hit_wr && i_req.wdata[ULSW_UNLOCK_BIT])
      |=> (unlock_r && swap_r == $past(i_req.wdata[NUM_PORTS-1:0])))
    else $error("unlock write did not load swap bits");
  a_unlocked_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    (unlock_r && !hit_wr) |=> $stable(swap_r))
    else $error("unlocked swap bits changed without write");
  a_locked_otp_src: assert property (@(posedge i_clk) disable iff (i_reset)
    !unlock_r |-> eff_swap == i_otp_swap)
    else $error("locked swap bits not from otp");
  a_read_otp_val: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.rd && i_req.addr == ULSW_CTRL_OFFSET && !unlock_r)
      |=> (o_rvalid && o_rdata[NUM_PORTS-1:0] == $past(i_otp_swap)))
    else $error("locked read did not return otp");
  a_rsvd_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    o_rvalid |-> o_rdata[ULSW_RSVD_HI:ULSW_RSVD_LO] == 2'b00)
    else $error("reserved bits read nonzero");
  a_straight_pins: assert property (@(posedge i_clk) disable iff (i_reset)
    !eff_swap[0] |=> (o_pin_dm[0] == $past(i_core[0].dm) && o_pin_dp[0] == $past(i_core[0].dp)))
    else $error("port 0 not in pinout order");
  a_swapped_pins: assert property (@(posedge i_clk) disable iff (i_reset)
    eff_swap[NUM_PORTS-1]
      |=> (o_pin_dm[NUM_PORTS-1] == $past(i_core[NUM_PORTS-1].dp)
        && o_pin_dp[NUM_PORTS-1] == $past(i_core[NUM_PORTS-1].dm)))
    else $error("top port not swapped");

  // access steps shared by the readback checks
  sequence s_unlock_write;
    hit_wr && i_req.wdata[ULSW_UNLOCK_BIT];
  endsequence
  sequence s_lock_write;
    hit_wr && !i_req.wdata[ULSW_UNLOCK_BIT];
  endsequence
  sequence s_quiet;
    !hit_wr;
  endsequence
  sequence s_ctrl_read;
    hit_rd && !hit_wr;
  endsequence
  sequence s_locked_read;
    hit_rd && !unlock_r;
  endsequence
  sequence s_unlocked_read;
    hit_rd && unlock_r;
  endsequence

  a_read_unlocked_val: assert property (@(posedge i_clk) disable iff (i_reset)
    s_unlocked_read
      |=> (o_rvalid && o_rdata[ULSW_UNLOCK_BIT]
        && o_rdata[ULSW_SWAP_LSB +: NUM_PORTS] == $past(swap_r)))
    else $error("unlocked read did not return stored bits");
  a_read_locked_flag: assert property (@(posedge i_clk) disable iff (i_reset)
    s_locked_read
      |=> (o_rvalid && !o_rdata[ULSW_UNLOCK_BIT]))
    else $error("locked read showed unlock set");

  // a write followed by a read two cycles on must show that write
  a_unlock_readback: assert property (@(posedge i_clk) disable iff (i_reset)
    s_unlock_write ##1 s_quiet ##1 s_ctrl_read
      |=> (o_rvalid
        && o_rdata == pack_reg(1'b1, $past(i_req.wdata[ULSW_SWAP_LSB +: NUM_PORTS], 3))))
    else $error("unlock write not seen on readback");
  a_lock_readback: assert property (@(posedge i_clk) disable iff (i_reset)
    s_lock_write ##1 s_quiet ##1 s_ctrl_read
      |=> (o_rvalid && o_rdata == pack_reg(1'b0, $past(i_otp_swap))))
    else $error("locked write leaked into readback");

  a_rvalid_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
    o_rvalid == $past(i_req.rd))
    else $error("read answer not one cycle after strobe");
  a_rdata_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_req.rd |=> $stable(o_rdata))
    else $error("read data changed without a read");

  a_swap_write_only: assert property (@(posedge i_clk) disable iff (i_reset)
    !hit_wr |=> ($stable(unlock_r) && $stable(swap_r)))
    else $error("stored bits changed without a write");
  a_locked_reload: assert property (@(posedge i_clk) disable iff (i_reset)
    s_lock_write |=> swap_r == $past(i_otp_swap))
    else $error("locked write stored its own data");

  // every port, not only the end ones
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_chk
    a_port_straight: assert property (@(posedge i_clk) disable iff (i_reset)
      !eff_swap[p]
        |=> (o_pin_dm[p] == $past(i_core[p].dm) && o_pin_dp[p] == $past(i_core[p].dp)))
      else $error("port lines not in pinout order");
    a_port_swapped: assert property (@(posedge i_clk) disable iff (i_reset)
      eff_swap[p]
        |=> (o_pin_dm[p] == $past(i_core[p].dp) && o_pin_dp[p] == $past(i_core[p].dm)))
      else $error("port lines not exchanged");
  end
endmodule : ulsw_line_swap_reg

//--- tb/ulsw_host_model.sv
// register access host model for the line swap register
module ulsw_host_model
  import ulsw_pkg::*;
(
  // clock
  input wire logic i_clk,
  // read answer
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  // request
  output ulsw_pkg::ulsw_req_s o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_req = '0;
  end
  // idle address and data flip and qualifiers clear so a stale address never passes for a live one
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic v);
    @(posedge i_clk);
    #1 o_req = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge i_clk);
    #1 q = i_rdata;
    v = i_rvalid;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : access
endmodule : ulsw_host_model

//--- tb/usb2_port_line_swap_register_tb.sv
// testbench for the usb2 line swap register
module usb2_port_line_swap_register_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ulsw_pkg::*;
  logic i_clk, i_reset, rvalid;
  logic [7:0] rdata;
  logic [4:0] otp, pin_dm, pin_dp;
  ulsw_req_s req;
  ulsw_pair_s [4:0] core;
  int n_errors = 0;
  int total_checks = 0;
  ulsw_line_swap_reg uut (.i_clk(i_clk), .i_reset(i_reset), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_otp_swap(otp), .i_core(core), .o_pin_dm(pin_dm), .o_pin_dp(pin_dp));
  ulsw_host_model host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic v;
    host.access(1'b0, a, 8'h00, q, v);
    chk("rvalid", {7'h00, v}, 8'h01);
    chk("rdata", q, exp);
  endtask : rd_chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic v;
    host.access(1'b1, a, d, q, v);
  endtask : wr_reg
  // a port keeps pinout order unless its swap bit is set
  task automatic pin_chk(input logic [4:0] swap);
    logic [4:0] e_dm, e_dp;
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 5; i++) begin
      e_dm[i] = swap[i] ? core[i].dp : core[i].dm;
      e_dp[i] = swap[i] ? core[i].dm : core[i].dp;
    end
    #2 chk("pin_dm", {3'h0, pin_dm}, {3'h0, e_dm});
    chk("pin_dp", {3'h0, pin_dp}, {3'h0, e_dp});
  endtask : pin_chk
  task automatic end_of_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    i_reset = 1'b1;
    otp = 5'h00;
    core = {5{2'b10}};
    repeat (5) @(posedge i_clk);
    #1 i_reset = 1'b0;
    rd_chk(ULSW_CTRL_OFFSET, ULSW_CTRL_RESET);
    otp = 5'h16;
    rd_chk(ULSW_CTRL_OFFSET, 8'h16);
    pin_chk(5'h16);
    wr_reg(ULSW_CTRL_OFFSET, 8'h1F);
    rd_chk(ULSW_CTRL_OFFSET, 8'h16);
    otp = 5'h09;
    rd_chk(ULSW_CTRL_OFFSET, 8'h09);
    wr_reg(ULSW_CTRL_OFFSET, 8'hE6);
    rd_chk(ULSW_CTRL_OFFSET, 8'h86);
    pin_chk(5'h06);
    core = {5{2'b01}};
    pin_chk(5'h06);
    wr_reg(8'h0C, 8'h80);
    rd_chk(ULSW_CTRL_OFFSET, 8'h86);
    rd_chk(8'h0C, 8'h00);
    // reset in mid-run must clear outputs and relock the swap bits
    i_reset = 1'b1;
    #2 chk("pin_dm", {3'h0, pin_dm}, 8'h00);
    chk("pin_dp", {3'h0, pin_dp}, 8'h00);
    chk("rvalid", {7'h00, rvalid}, 8'h00);
    repeat (2) @(posedge i_clk);
    #1 i_reset = 1'b0;
    rd_chk(ULSW_CTRL_OFFSET, 8'h09);
    pin_chk(5'h09);
    core = 10'h2D9;
    wr_reg(ULSW_CTRL_OFFSET, 8'h95);
    rd_chk(ULSW_CTRL_OFFSET, 8'h95);
    pin_chk(5'h15);
    wr_reg(ULSW_CTRL_OFFSET, 8'h1F);
    rd_chk(ULSW_CTRL_OFFSET, 8'h09);
    pin_chk(5'h09);
    end_of_test();
  end
endmodule : usb2_port_line_swap_register_tb
